/* core/linkage_pkg.sv */
// linkage_pkg: constants, commands and states for the linkage sequencer.
// assumes a 16-bit word machine with byte addresses and word-aligned stack.
package linkage_pkg;

  // ----------------------------------------------------------------
  // register numbering and address arithmetic
  // ----------------------------------------------------------------
  localparam logic [2:0] hardware_stack_pointer_reg = 3'h6;
  localparam logic [2:0] program_counter_reg = 3'h7;
  localparam logic [15:0] word_bytes = 16'h0002;   // one word step in bytes

  // ----------------------------------------------------------------
  // values after reset
  // ----------------------------------------------------------------
  localparam logic [15:0] pc_reset = 16'h0000;
  localparam logic [15:0] sp_reset = 16'h0000;
  localparam logic [15:0] gpr_reset = 16'h0000;
  localparam logic [15:0] status_reset = 16'h0000;

  // ----------------------------------------------------------------
  // commands from the instruction decoder
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    cmd_none,
    subroutine_call_instr,
    subroutine_return,
    plain_jump_instr,
    arg_fetch_autoinc,
    interrupt_return_instr
  } cmd_e;

  // ----------------------------------------------------------------
  // sequencer states
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    st_idle,
    st_call_push,
    st_ret_pop,
    st_arg_read,
    st_int_push_status,
    st_int_push_pc,
    st_int_vec_pc,
    st_int_vec_status,
    st_rti_pop_pc,
    st_rti_pop_status
  } state_e;

endpackage : linkage_pkg

/* core/subroutine_interrupt_linkage.sv */
// subroutine_interrupt_linkage: call, return, jump, argument fetch,
// interrupt entry and interrupt return sequencing over a word memory port.
// assumes the memory holds stack and vectors and answers each request with
// mem_ack; commands and interrupt request come synchronous to mclk.
//
// Operation
// - autoincrement argument fetch advances linkage register
// - return copies register to pc, then pops
// - return naming pc resumes at popped word
// - plain jump saves nothing, pushes nothing
// - interrupt pushes status word, then pc
// - vector word one to pc, two to status
// - interrupt return pops pc, then status
// - vectors live in ordinary writable memory
// - call may name pc as linkage register
// - call pushes register, loads return, jumps
// - stack grows down, sp marks last push
// - stack pointer holds even addresses unless a call names it while pc is odd
`timescale 1ns/1ps
`default_nettype none

module subroutine_interrupt_linkage
  import linkage_pkg::*;
(
  input wire logic mclk,               // processor clock, 125 MHz
  input wire logic rst_n,              // async reset, active low
  input wire logic cmd_valid,          // command offered this cycle
  output logic cmd_ready,              // sequencer idle, command taken
  input wire cmd_e cmd_op,             // which linkage command
  input wire logic [2:0] cmd_reg,      // linkage register number
  input wire logic [15:0] cmd_target,  // jump or call destination
  input wire logic instr_boundary,     // decoder sits between instructions
  input wire logic int_req,            // interrupt pending
  input wire logic [15:0] int_vector,  // vector base address
  output logic int_ack,                // interrupt taken, one cycle
  input wire logic reg_we,             // datapath register write
  input wire logic [2:0] reg_waddr,    // datapath register number
  input wire logic [15:0] reg_wdata,   // datapath register data
  input wire logic status_we,          // datapath status write
  input wire logic [15:0] status_wdata, // datapath status data
  output logic mem_req,                // memory cycle requested
  output logic mem_we,                 // memory cycle is a write
  output logic [15:0] mem_addr,        // memory byte address (even unless sp is odd)
  output logic [15:0] mem_wdata,       // memory write data
  input wire logic [15:0] mem_rdata,   // memory read data
  input wire logic mem_ack,            // memory cycle complete
  output logic [15:0] program_counter, // current pc
  output logic [15:0] stack_pointer,   // current hardware stack pointer
  output logic [15:0] processor_status_word, // current status word
  output logic [15:0] arg_data,        // last fetched argument word
  output logic done                    // command finished, one cycle
);

  // ----------------------------------------------------------------
  // state and helpers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [7:0][15:0] regs;
    logic [15:0] status;
    state_e state;
    logic [2:0] ridx;
    logic [15:0] addr;
    logic [15:0] wdata;
    logic [15:0] vec;
    logic [15:0] arg;
    logic done;
    logic iack;
  } link_s;

  link_s cur;
  link_s next_cur;

  // word step up or down; bit 0 cleared so each stack step lands on an even address
  function automatic logic [15:0] word_step(input logic [15:0] a, input logic down);
    logic [15:0] r;
    r = down ? (a - word_bytes) : (a + word_bytes);
    return {r[15:1], 1'b0};
  endfunction : word_step

  function automatic logic [15:0] even(input logic [15:0] a);
    return {a[15:1], 1'b0};
  endfunction : even

  // ----------------------------------------------------------------
  // next-state logic
  // ----------------------------------------------------------------
  always_comb begin
    logic [15:0] sp_dec;
    sp_dec = word_step(cur.regs[hardware_stack_pointer_reg], 1'b1);
    next_cur = cur;
    next_cur.done = 1'b0;
    next_cur.iack = 1'b0;
    unique case (cur.state)
      st_idle: begin
        // datapath writes only while idle so sequences see stable registers
        if (reg_we) begin
          next_cur.regs[reg_waddr] = reg_wdata;
          if (reg_waddr == hardware_stack_pointer_reg) begin
            next_cur.regs[reg_waddr] = even(reg_wdata);
          end
        end
        if (status_we) begin
          next_cur.status = status_wdata;
        end
        // pending interrupt wins over a new command, but only between
        // instructions, so the saved pc is the next instruction
        if (int_req && instr_boundary) begin
          next_cur.iack = 1'b1;
          next_cur.vec = even(int_vector);
          next_cur.regs[hardware_stack_pointer_reg] = sp_dec;
          next_cur.addr = sp_dec;
          next_cur.wdata = status_we ? status_wdata : cur.status;
          next_cur.state = st_int_push_status;
        end else if (cmd_valid) begin
          next_cur.ridx = cmd_reg;
          unique case (cmd_op)
            subroutine_call_instr: begin
              // push old linkage contents first; for the pc this is the
              // return address itself
              next_cur.regs[hardware_stack_pointer_reg] = sp_dec;
              next_cur.addr = sp_dec;
              next_cur.wdata = cur.regs[cmd_reg];
              next_cur.state = st_call_push;
            end
            subroutine_return: begin
              next_cur.regs[program_counter_reg] = cur.regs[cmd_reg];
              next_cur.addr = cur.regs[hardware_stack_pointer_reg];
              next_cur.state = st_ret_pop;
            end
            plain_jump_instr: begin
              next_cur.regs[program_counter_reg] = cmd_target;
              next_cur.done = 1'b1;
            end
            arg_fetch_autoinc: begin
              next_cur.addr = even(cur.regs[cmd_reg]);
              next_cur.state = st_arg_read;
            end
            interrupt_return_instr: begin
              next_cur.addr = cur.regs[hardware_stack_pointer_reg];
              next_cur.state = st_rti_pop_pc;
            end
            default: begin
              next_cur.done = 1'b1;
            end
          endcase
          next_cur.vec = cmd_target;
        end
      end
      st_call_push: begin
        if (mem_ack) begin
          // linkage register now holds the address after the call
          next_cur.regs[cur.ridx] = cur.regs[program_counter_reg];
          next_cur.regs[program_counter_reg] = cur.vec;
          next_cur.done = 1'b1;
          next_cur.state = st_idle;
        end
      end
      st_ret_pop: begin
        if (mem_ack) begin
          // naming pc overwrites the copy just made: resume at popped word
          next_cur.regs[cur.ridx] = mem_rdata;
          next_cur.regs[hardware_stack_pointer_reg] = word_step(cur.addr, 1'b0);
          next_cur.done = 1'b1;
          next_cur.state = st_idle;
        end
      end
      st_arg_read: begin
        if (mem_ack) begin
          next_cur.arg = mem_rdata;
          next_cur.regs[cur.ridx] = cur.addr + word_bytes;
          if (cur.ridx == hardware_stack_pointer_reg) begin
            next_cur.regs[cur.ridx] = word_step(cur.addr, 1'b0);
          end
          next_cur.done = 1'b1;
          next_cur.state = st_idle;
        end
      end
      st_int_push_status: begin
        if (mem_ack) begin
          next_cur.regs[hardware_stack_pointer_reg] = sp_dec;
          next_cur.addr = sp_dec;
          next_cur.wdata = cur.regs[program_counter_reg];
          next_cur.state = st_int_push_pc;
        end
      end
      st_int_push_pc: begin
        if (mem_ack) begin
          // vectors are ordinary memory words, read like any data
          next_cur.addr = cur.vec;
          next_cur.state = st_int_vec_pc;
        end
      end
      st_int_vec_pc: begin
        if (mem_ack) begin
          next_cur.regs[program_counter_reg] = mem_rdata;
          next_cur.addr = cur.vec + word_bytes;
          next_cur.state = st_int_vec_status;
        end
      end
      st_int_vec_status: begin
        if (mem_ack) begin
          next_cur.status = mem_rdata;
          next_cur.done = 1'b1;
          next_cur.state = st_idle;
        end
      end
      st_rti_pop_pc: begin
        if (mem_ack) begin
          next_cur.regs[program_counter_reg] = mem_rdata;
          next_cur.addr = word_step(cur.addr, 1'b0);
          next_cur.state = st_rti_pop_status;
        end
      end
      st_rti_pop_status: begin
        if (mem_ack) begin
          next_cur.status = mem_rdata;
          next_cur.regs[hardware_stack_pointer_reg] = word_step(cur.addr, 1'b0);
          next_cur.done = 1'b1;
          next_cur.state = st_idle;
        end
      end
    endcase
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      cur.regs <= {8{gpr_reset}};
      cur.regs[hardware_stack_pointer_reg] <= sp_reset;
      cur.regs[program_counter_reg] <= pc_reset;
      cur.status <= status_reset;
      cur.state <= st_idle;
      cur.ridx <= 3'h0;
      cur.addr <= 16'h0000;
      cur.wdata <= 16'h0000;
      cur.vec <= 16'h0000;
      cur.arg <= 16'h0000;
      cur.done <= 1'b0;
      cur.iack <= 1'b0;
    end else begin
      cur <= next_cur;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  // interrupt has priority, so a command is refused at that edge
  assign cmd_ready = (cur.state == st_idle) && !(int_req && instr_boundary);
  assign mem_req = (cur.state != st_idle);
  assign mem_we = (cur.state == st_call_push) || (cur.state == st_int_push_status) ||
                  (cur.state == st_int_push_pc);
  assign mem_addr = cur.addr;
  assign mem_wdata = cur.wdata;
  assign program_counter = cur.regs[program_counter_reg];
  assign stack_pointer = cur.regs[hardware_stack_pointer_reg];
  assign processor_status_word = cur.status;
  assign arg_data = cur.arg;
  assign done = cur.done;
  assign int_ack = cur.iack;

endmodule : subroutine_interrupt_linkage

`default_nettype wire

/* test/linkage_mem_model.sv */
// memory model: word store holding the stack and the vectors.
// assumes byte addresses below 16'h0800 and requests held until ack.
`timescale 1ns/1ps
`default_nettype none
module linkage_mem_model (
  input wire logic mclk, // clock
  input wire logic rst_n, // reset, active low
  input wire logic slow, // two wait states
  input wire logic mem_req, // request
  input wire logic mem_we, // write
  input wire logic [15:0] mem_addr, // byte address
  input wire logic [15:0] mem_wdata, // write data
  output logic [15:0] mem_rdata, // read data
  output logic mem_ack // cycle complete
);
  logic [15:0] mem [0:1023];
  logic [1:0] waits;
  // read bus toggles outside an ack so stale data never looks valid
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      mem_ack <= 1'b0;
      waits <= 2'h0;
      mem_rdata <= 16'h0000;
    end else if (mem_req && !mem_ack && waits == (slow ? 2'h2 : 2'h0)) begin
      mem_ack <= 1'b1;
      waits <= 2'h0;
      mem_rdata <= mem[mem_addr[10:1]];
      if (mem_we) mem[mem_addr[10:1]] <= mem_wdata;
    end else begin
      mem_ack <= 1'b0;
      mem_rdata <= ~mem_rdata;
      waits <= (mem_req && !mem_ack) ? waits + 2'h1 : 2'h0;
    end
  end
endmodule : linkage_mem_model
`default_nettype wire

/* test/subroutine_interrupt_linkage_checker.sv */
// checker: port relations of the linkage sequencer.
// assumes one clock domain; bound onto every instance.
`timescale 1ns/1ps
`default_nettype none
module subroutine_interrupt_linkage_checker
  import linkage_pkg::*;
(
  input wire logic mclk, // clock
  input wire logic rst_n, // reset
  input wire logic cmd_valid, // command offered
  input wire logic cmd_ready, // command taken
  input wire cmd_e cmd_op, // command
  input wire logic [15:0] cmd_target, // destination
  input wire logic instr_boundary, // between instructions
  input wire logic int_req, // interrupt pending
  input wire logic int_ack, // interrupt taken
  input wire logic mem_req, // memory request
  input wire logic mem_we, // memory write
  input wire logic [15:0] mem_addr, // memory address
  input wire logic [15:0] mem_wdata, // memory data
  input wire logic mem_ack, // memory ack
  input wire logic [15:0] program_counter, // pc
  input wire logic [15:0] stack_pointer, // sp
  input wire logic [15:0] processor_status_word, // status
  input wire logic done // finished
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  // a command is taken only when offered and ready together
  logic take;
  assign take = cmd_valid && cmd_ready;
  a_sp_word_even: assert property (!stack_pointer[0]) else $error("sp odd");
  a_jump_no_push: assert property (take && cmd_op == plain_jump_instr |=> done && !mem_req
    && $stable(stack_pointer) && program_counter == $past(cmd_target)) else $error("jump wrong");
  a_call_predec: assert property (take && cmd_op == subroutine_call_instr |=> mem_req && mem_we
    && mem_addr == $past(stack_pointer) - 16'h0002 && stack_pointer == mem_addr) else $error("call push");
  a_ret_top_read: assert property (take && cmd_op == subroutine_return |=> mem_req && !mem_we
    && mem_addr == $past(stack_pointer)) else $error("return pop");
  a_rti_top_read: assert property (take && cmd_op == interrupt_return_instr |=> mem_req
    && !mem_we && mem_addr == $past(stack_pointer)) else $error("rti pop");
  a_int_push_status: assert property ($rose(int_ack) |-> mem_req && mem_we && mem_addr == stack_pointer
    && mem_wdata == processor_status_word) else $error("status push");
  a_int_at_boundary: assert property ($rose(int_ack) |-> $past(int_req)
    && $past(instr_boundary)) else $error("interrupt off boundary");
  a_int_ends_bound: assert property ($rose(int_ack) |-> ##[4:60] done) else $error("entry hung");
  a_req_stands: assert property (mem_req && !mem_ack |=> mem_req
    && $stable(mem_addr) && $stable(mem_we)) else $error("request dropped");
  a_int_refuses_cmd: assert property (int_req && instr_boundary |-> !cmd_ready) else $error("cmd over int");
  c_call: cover property (take && cmd_op == subroutine_call_instr);
  c_int: cover property ($rose(int_ack));
  c_rti: cover property (take && cmd_op == interrupt_return_instr);
endmodule : subroutine_interrupt_linkage_checker
bind subroutine_interrupt_linkage subroutine_interrupt_linkage_checker u_chk (.mclk, .rst_n, .cmd_valid,
  .cmd_ready, .cmd_op, .cmd_target, .instr_boundary, .int_req, .int_ack, .mem_req, .mem_we, .mem_addr,
  .mem_wdata, .mem_ack, .program_counter, .stack_pointer, .processor_status_word, .done);
`default_nettype wire

/* test/subroutine_interrupt_linkage_tb.sv */
// testbench: call, argument, return, jump, interrupt entry and return.
// assumes inputs change at the falling edge and the memory model opposite.
`timescale 1ns/1ps
`default_nettype none
module subroutine_interrupt_linkage_tb;
  import linkage_pkg::*;
  logic mclk = 1'b0, rst_n = 1'b0, cmd_valid = 1'b0, instr_boundary = 1'b1, int_req = 1'b0;
  logic reg_we = 1'b0, status_we = 1'b0, slow = 1'b0;
  cmd_e cmd_op = cmd_none;
  logic [2:0] cmd_reg = 3'h0, reg_waddr = 3'h0;
  logic [15:0] cmd_target = 16'h0000, int_vector = 16'h0000, reg_wdata = 16'h0000, status_wdata = 16'h0000;
  logic cmd_ready, int_ack, mem_req, mem_we, mem_ack, done;
  logic [15:0] mem_addr, mem_wdata, mem_rdata, program_counter, stack_pointer, processor_status_word, arg_data;
  int miscompares = 0, num_checks = 0;
  always #4 mclk = ~mclk;
  subroutine_interrupt_linkage u_dut (.mclk, .rst_n, .cmd_valid, .cmd_ready, .cmd_op, .cmd_reg, .cmd_target,
    .instr_boundary, .int_req, .int_vector, .int_ack, .reg_we, .reg_waddr, .reg_wdata, .status_we,
    .status_wdata, .mem_req, .mem_we, .mem_addr, .mem_wdata, .mem_rdata, .mem_ack, .program_counter,
    .stack_pointer, .processor_status_word, .arg_data, .done);
  linkage_mem_model u_mem (.mclk, .rst_n, .slow, .mem_req, .mem_we, .mem_addr, .mem_wdata, .mem_rdata, .mem_ack);
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    num_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  // bounded wait so a lost done shows up as a mismatch, not a hang
  task automatic wait_done;
    int n;
    n = 0;
    while (done !== 1'b1 && n < 60) begin
      @(negedge mclk);
      n++;
    end
    chk("done", 16'h0001, {15'h0000, done});
  endtask : wait_done
  task automatic wreg(input logic [2:0] r, input logic [15:0] d);
    reg_waddr = r;
    reg_wdata = d;
    reg_we = 1'b1;
    @(negedge mclk);
    reg_we = 1'b0;
    // let one edge pass so a following write never re-raises the strobe at once
    @(negedge mclk);
  endtask : wreg
  task automatic run(input cmd_e op, input logic [2:0] r, input logic [15:0] t);
    cmd_op = op;
    cmd_reg = r;
    cmd_target = t;
    cmd_valid = 1'b1;
    @(negedge mclk);
    cmd_valid = 1'b0;
    wait_done();
    // one idle edge so the next command never re-raises valid in this step
    @(negedge mclk);
  endtask : run
  task automatic t_call_arg_ret;
    wreg(3'h6, 16'h0100);
    wreg(3'h5, 16'h0234);
    wreg(3'h7, 16'h0400);
    u_mem.mem[10'h200] = 16'haaaa;
    u_mem.mem[10'h201] = 16'hbbbb;
    u_mem.mem[10'h11a] = 16'h5a5a;
    run(subroutine_call_instr, 3'h5, 16'h2000);
    chk("call pc", 16'h2000, program_counter);
    chk("call sp", 16'h00fe, stack_pointer);
    chk("pushed", 16'h0234, u_mem.mem[10'h07f]);
    run(arg_fetch_autoinc, 3'h5, 16'h0000);
    chk("arg1", 16'haaaa, arg_data);
    run(arg_fetch_autoinc, 3'h5, 16'h0000);
    chk("arg2", 16'hbbbb, arg_data);
    run(subroutine_return, 3'h5, 16'h0000);
    chk("ret pc", 16'h0404, program_counter);
    chk("ret sp", 16'h0100, stack_pointer);
    run(arg_fetch_autoinc, 3'h5, 16'h0000);
    chk("restored", 16'h5a5a, arg_data);
  endtask : t_call_arg_ret
  task automatic t_pc_link;
    wreg(3'h7, 16'h0600);
    run(subroutine_call_instr, 3'h7, 16'h3000);
    chk("pc pushed", 16'h0600, u_mem.mem[10'h07f]);
    chk("target", 16'h3000, program_counter);
    run(subroutine_return, 3'h7, 16'h0000);
    chk("resume", 16'h0600, program_counter);
    chk("sp back", 16'h0100, stack_pointer);
  endtask : t_pc_link
  task automatic t_jump;
    wreg(3'h6, 16'h0101);
    chk("sp even", 16'h0100, stack_pointer);
    run(plain_jump_instr, 3'h5, 16'h1110);
    run(plain_jump_instr, 3'h5, 16'h2220);
    chk("jump pc", 16'h2220, program_counter);
    chk("jump sp", 16'h0100, stack_pointer);
    run(cmd_none, 3'h0, 16'h0000);
    chk("none pc", 16'h2220, program_counter);
    chk("none sp", 16'h0100, stack_pointer);
  endtask : t_jump
  // slow memory here: entry and return must hold through wait states
  task automatic t_int_rti;
    slow = 1'b1;
    status_wdata = 16'h00e5;
    status_we = 1'b1;
    @(negedge mclk);
    status_we = 1'b0;
    wreg(3'h7, 16'h0700);
    u_mem.mem[10'h020] = 16'h5000;
    u_mem.mem[10'h021] = 16'h00c0;
    int_vector = 16'h0040;
    instr_boundary = 1'b0;
    int_req = 1'b1;
    repeat (6) @(negedge mclk);
    chk("held", 16'h0700, program_counter);
    instr_boundary = 1'b1;
    @(negedge mclk);
    int_req = 1'b0;
    wait_done();
    chk("vec pc", 16'h5000, program_counter);
    chk("vec status", 16'h00c0, processor_status_word);
    chk("int sp", 16'h00fc, stack_pointer);
    chk("saved status", 16'h00e5, u_mem.mem[10'h07f]);
    chk("saved pc", 16'h0700, u_mem.mem[10'h07e]);
    run(interrupt_return_instr, 3'h0, 16'h0000);
    chk("rti pc", 16'h0700, program_counter);
    chk("rti status", 16'h00e5, processor_status_word);
    chk("rti sp", 16'h0100, stack_pointer);
  endtask : t_int_rti
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : tally_and_finish
  initial begin
    repeat (10) @(negedge mclk);
    rst_n = 1'b1;
    @(negedge mclk);
    t_call_arg_ret();
    t_pc_link();
    t_jump();
    t_int_rti();
    tally_and_finish();
  end
  // watchdog well beyond the hundred or so cycles the tests need
  initial begin
    #40000;
    miscompares++;
    tally_and_finish();
  end
endmodule : subroutine_interrupt_linkage_tb
`default_nettype wire
